// ===== shared/tcc_map.svh
// Constants for the compare-toggle timer channel
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
`define TCC_KEY_OPEN      16'ha502
`define TCC_KEY_CLOSE     16'ha500
`define TCC_PROT_RST      16'h0000
`define TCC_PSC_UNDIV     3'h0
`define TCC_PSC_DIV4      3'h1
`define TCC_PSC_DIV16     3'h2
`define TCC_PSC_DIV64     3'h3
`define TCC_CLR_NONE      3'h0
`define TCC_CLR_MATCH_A   3'h1
`define TCC_IO_TOGGLE_LO  4'h3
`define TCC_MODE_NORMAL   4'h0
`define TCC_PINFN_TIMER   6'h01
`define TCC_PINFN_RST     6'h00
`define TCC_CNT_RST       16'h0000
`define TCC_DIV_W         6
`endif

// ===== shared/tcc_pkg.sv
// Types for the compare-toggle timer channel
`default_nettype none
package tcc_pkg;
  // Channel setup fields, held by the surrounding register logic
  typedef struct packed {
    logic [2:0] prescalerSelect;
    logic [1:0] clockEdgeSelect;
    logic [2:0] counterClearSelect;
    logic [3:0] regAIoMode;
    logic [3:0] operatingModeField;
    logic       bufferASelect;
    logic       bufferBSelect;
  } tcc_cfg_t;
  // Pin-function access group
  typedef struct packed {
    logic       lockWr;
    logic       lockData;
    logic       pfsWeWr;
    logic       pfsWeData;
    logic       pfsWr;
    logic [5:0] pfsData;
  } tcc_pin_cfg_t;
endpackage
`default_nettype wire

// ===== src/tcc_channel.sv
// Compare-toggle timer channel with module stop, key and pin routing
`timescale 1ns/10ps
`default_nettype none
`include "tcc_map.svh"
module tcc_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  protWr,
  input  wire logic [15:0]           protData,
  input  wire logic                  modStopWr,
  input  wire logic                  modStopData,
  input  wire logic                  channelStart,
  input  wire tcc_pkg::tcc_cfg_t     cfg,
  input  wire logic                  ioModeWr,
  input  wire logic                  cntWr,
  input  wire logic [CNT_W-1:0]      cntData,
  input  wire logic                  genAWr,
  input  wire logic [CNT_W-1:0]      genAData,
  input  wire logic                  outMasterEnable,
  input  wire tcc_pkg::tcc_pin_cfg_t pinCfg,
  input  wire logic                  portModePeriph,
  input  wire logic                  vectorSelect,
  input  wire logic                  otherUnitIrq,
  output logic                       pulsePinOut,
  output logic                       pulsePinOe,
  output logic                       moduleStopped,
  output logic [CNT_W-1:0]           channelCounter,
  output logic [CNT_W-1:0]           generalRegA,
  output logic                       sharedVectorIrq
);
  // Mask of divider bits that must be zero for a count tick
  function automatic logic [`TCC_DIV_W-1:0] divMask(input logic [2:0] psc);
    unique case (psc)
      `TCC_PSC_DIV4:  divMask = 6'h03;
      `TCC_PSC_DIV16: divMask = 6'h0f;
      `TCC_PSC_DIV64: divMask = 6'h3f;
      default:        divMask = 6'h00;
    endcase
  endfunction

  logic [15:0]           protReg;     // Last key written
  logic [`TCC_DIV_W-1:0] preDiv;      // Free divider for slow ticks
  logic                  outLevel;    // Timer output level
  logic                  matchIrq;    // Registered match event
  logic                  pinLock;     // Pin-function write lock
  logic                  pin_func_write_enable;       // Pin-function write enable
  logic [5:0]            pinFunc;     // Pin function code

  // Decode of the running condition
  wire normalMode = (cfg.operatingModeField == `TCC_MODE_NORMAL) &&
                    !cfg.bufferASelect && !cfg.bufferBSelect;
  wire enabled    = !moduleStopped && channelStart && normalMode;
  // Internal clock: every edge setting counts once per tick
  wire countTick  = enabled &&
                    ((preDiv & divMask(cfg.prescalerSelect)) == 6'h00);
  wire match      = countTick && (channelCounter == generalRegA);
  wire clearOnA   = cfg.counterClearSelect == `TCC_CLR_MATCH_A;
  wire keyOpen    = protReg == `TCC_KEY_OPEN;
  wire pfsAllowed = !pinLock && pin_func_write_enable;
  wire timerOwns  = outMasterEnable && portModePeriph &&
                    (pinFunc == `TCC_PINFN_TIMER) && !moduleStopped;
  wire regWrOk    = !moduleStopped;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      protReg <= `TCC_PROT_RST;
    end else if (protWr) begin
      protReg <= protData;
    end
  end

  // stopped out of reset
  // A stray write without the key must not wake the block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      moduleStopped <= 1'b1;
    end else if (modStopWr && keyOpen) begin
      moduleStopped <= modStopData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !enabled) begin
      preDiv <= '0;
    end else begin
      preDiv <= preDiv + 6'h01;
    end
  end

  // counter: software write beats count and clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      channelCounter <= `TCC_CNT_RST;
    end else if (cntWr && regWrOk) begin
      channelCounter <= cntData;
    end else if (match && clearOnA) begin
      channelCounter <= `TCC_CNT_RST;
    end else if (countTick) begin
      channelCounter <= channelCounter + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      generalRegA <= `TCC_CNT_RST;
    end else if (genAWr && regWrOk) begin
      generalRegA <= genAData;
    end
  end

  // initial level on setup, action on match
  // Mode bit 2 gives the initial level, bits 1:0 the match action
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outLevel <= 1'b0;
    end else if (ioModeWr && regWrOk) begin
      outLevel <= cfg.regAIoMode[2];
    end else if (match) begin
      unique case (cfg.regAIoMode[1:0])
        2'h1:    outLevel <= 1'b0;
        2'h2:    outLevel <= 1'b1;
        2'h3:    outLevel <= !outLevel;
        default: outLevel <= outLevel;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinLock <= 1'b1;
      pin_func_write_enable   <= 1'b0;
      pinFunc <= `TCC_PINFN_RST;
    end else begin
      if (pinCfg.lockWr) begin
        pinLock <= pinCfg.lockData;
      end
      // Enable can only move while the lock is open
      if (pinCfg.pfsWeWr && !pinLock) begin
        pin_func_write_enable <= pinCfg.pfsWeData;
      end
      if (pinCfg.pfsWr && pfsAllowed) begin
        pinFunc <= pinCfg.pfsData;
      end
    end
  end

  // Match event for the shared vector
  always_ff @(posedge core_clk) begin
    if (rst) begin
      matchIrq <= 1'b0;
    end else begin
      matchIrq <= match;
    end
  end

  // vector selector picks one unit only
  assign sharedVectorIrq = vectorSelect ? otherUnitIrq : matchIrq;
  // hardware drives the pin once routed, with master enable set and the module running
  assign pulsePinOe  = timerOwns;
  assign pulsePinOut = timerOwns & outLevel;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Selector judged in the same cycle as the output it steers
  AST_VECTOR: assert property (
    !vectorSelect |-> sharedVectorIrq == $past(match))
    else $error("vector not carrying own match");
  AST_STOP_HOLD: assert property (
    moduleStopped |=> $stable(channelCounter))
    else $error("counter moved while stopped");
  AST_KEY: assert property (
    modStopWr && !keyOpen |=> $stable(moduleStopped))
    else $error("stop bit changed without key");
  AST_HALT: assert property (
    !channelStart && !cntWr |=> $stable(channelCounter))
    else $error("counter moved with start clear");
  AST_UNDIV: assert property (
    enabled && cfg.prescalerSelect == `TCC_PSC_UNDIV && !match && !cntWr
    |=> channelCounter == $past(channelCounter) + 16'h0001)
    else $error("undivided count missed");
  AST_CLEAR: assert property (
    match && clearOnA && !cntWr |=> channelCounter == 16'h0000)
    else $error("no clear on match");
  AST_PIN_OE: assert property (
    pulsePinOe |-> outMasterEnable)
    else $error("pin driven without master enable");
  AST_INIT_LOW: assert property (
    ioModeWr && regWrOk && cfg.regAIoMode == `TCC_IO_TOGGLE_LO
    |=> !outLevel)
    else $error("initial level not low");
  AST_TOGGLE: assert property (
    match && !ioModeWr && cfg.regAIoMode == `TCC_IO_TOGGLE_LO
    |=> outLevel != $past(outLevel))
    else $error("no toggle on match");
  AST_MODE: assert property (
    !normalMode && !cntWr |=> $stable(channelCounter))
    else $error("counted outside normal mode");
  AST_PFS: assert property (
    pinCfg.pfsWr && !pfsAllowed |=> $stable(pinFunc))
    else $error("pin function written while locked");
  AST_WRITE: assert property (
    cntWr && regWrOk |=> channelCounter == $past(cntData))
    else $error("counter write lost");

  COV_RELEASE: cover property (
    moduleStopped ##1 !moduleStopped);
  COV_TOGGLE: cover property (
    match && clearOnA ##[1:100] match);
  COV_PIN: cover property (
    timerOwns && outLevel ##[1:100] timerOwns && !outLevel);
endmodule
`default_nettype wire

// ===== test/tcc_load.sv
// Load model on the pulse pin, measuring the half period of the wave
`timescale 1ns/10ps
`default_nettype none
module tcc_load (
  input  wire logic        core_clk,
  input  wire logic        pinOut,
  input  wire logic        pinOe,
  output logic             pinLevel,
  output logic [15:0]      halfLen
);
  logic        prevLevel;  // Level seen at the last edge
  logic [15:0] runLen;     // Cycles since the last pin change
  // undriven pin: the board pull-down holds it low while released
  assign pinLevel = pinOe ? pinOut : 1'b0;
  // Time between pin changes; the first figure is unknown, as runLen has no reset
  always_ff @(posedge core_clk) begin
    prevLevel <= pinLevel;
    if (pinLevel != prevLevel) begin
      halfLen <= runLen + 16'h0001;
      runLen  <= 16'h0000;
    end else begin
      runLen <= runLen + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== test/timer_channel_compare_toggle_bench.sv
// Self-checking bench for the compare-toggle timer channel
`timescale 1ns/10ps
`default_nettype none
`include "tcc_map.svh"
module timer_channel_compare_toggle_bench;
  logic core_clk, rst, protWr, modStopWr, modStopData, channelStart;
  logic ioModeWr, cntWr, genAWr, outMasterEnable, portModePeriph;
  logic vectorSelect, otherUnitIrq, pulsePinOut, pulsePinOe;
  logic moduleStopped, sharedVectorIrq, pinLevel;
  logic [15:0] protData, cntData, genAData, channelCounter, generalRegA;
  logic [15:0] halfLen, held;
  tcc_pkg::tcc_cfg_t     cfg;
  tcc_pkg::tcc_pin_cfg_t pinCfg;
  int mismatches, nChecks, irqs;
  tcc_channel i_dut (.core_clk(core_clk), .rst(rst), .protWr(protWr),
    .protData(protData), .modStopWr(modStopWr), .modStopData(modStopData),
    .channelStart(channelStart), .cfg(cfg), .ioModeWr(ioModeWr),
    .cntWr(cntWr), .cntData(cntData), .genAWr(genAWr), .genAData(genAData),
    .outMasterEnable(outMasterEnable), .pinCfg(pinCfg),
    .portModePeriph(portModePeriph), .vectorSelect(vectorSelect),
    .otherUnitIrq(otherUnitIrq), .pulsePinOut(pulsePinOut),
    .pulsePinOe(pulsePinOe), .moduleStopped(moduleStopped),
    .channelCounter(channelCounter), .generalRegA(generalRegA),
    .sharedVectorIrq(sharedVectorIrq));
  tcc_load i_load (.core_clk(core_clk), .pinOut(pulsePinOut),
    .pinOe(pulsePinOe), .pinLevel(pinLevel), .halfLen(halfLen));
  // Free-running 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Compare and count; a mismatch is reported at once
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    nChecks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Drop every write pulse at the next edge, then let outputs settle
  task idle();
    @(posedge core_clk);
    {protWr, modStopWr, ioModeWr, cntWr, genAWr} <= 5'h00;
    pinCfg <= '0;
    #1;
  endtask
  task give_verdict();
    if (mismatches == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Stopped module refuses a release without the key and refuses writes
  task t_stopped();
    chk("stopped", 16'h0001, moduleStopped);
    @(posedge core_clk) {modStopWr, modStopData, genAWr} <= 3'h5;
    genAData <= 16'h00aa;
    idle();
    chk("nokey", 16'h0001, moduleStopped);
    chk("regA", 16'h0000, generalRegA);
  endtask
  // Key opens the stop control, closing key locks it again
  task t_release();
    @(posedge core_clk) {protWr, protData} <= {1'b1, `TCC_KEY_OPEN};
    idle();
    @(posedge core_clk) {modStopWr, modStopData} <= 2'h2;
    idle();
    chk("released", 16'h0000, moduleStopped);
    @(posedge core_clk) {protWr, protData} <= {1'b1, `TCC_KEY_CLOSE};
    idle();
    @(posedge core_clk) {modStopWr, modStopData} <= 2'h3;
    idle();
    chk("relocked", 16'h0000, moduleStopped);
  endtask
  // Pin function write while locked is refused; the full sequence routes
  task t_route();
    @(posedge core_clk) {pinCfg.pfsWr, pinCfg.pfsData} <= 7'h41;
    {outMasterEnable, portModePeriph} <= 2'h3;
    idle();
    chk("oeLocked", 16'h0000, pulsePinOe);
    @(posedge core_clk) pinCfg.lockWr <= 1'b1;
    idle();
    @(posedge core_clk) {pinCfg.pfsWeWr, pinCfg.pfsWeData} <= 2'h3;
    idle();
    @(posedge core_clk) {pinCfg.pfsWr, pinCfg.pfsData} <= 7'h41;
    idle();
    @(posedge core_clk) {pinCfg.lockWr, pinCfg.lockData} <= 2'h3;
    idle();
    chk("oeRouted", 16'h0001, pulsePinOe);
    @(posedge core_clk) outMasterEnable <= 1'b0;
    idle();
    chk("oeMaster", 16'h0000, pulsePinOe);
    @(posedge core_clk) outMasterEnable <= 1'b1;
  endtask
  // Half period of N+1 cycles, one vector pulse each match, stop holds
  task t_pulse();
    @(posedge core_clk) cfg <= '{`TCC_PSC_UNDIV, 2'h0, `TCC_CLR_MATCH_A,
      `TCC_IO_TOGGLE_LO, `TCC_MODE_NORMAL, 1'b0, 1'b0};
    // half period minus one goes into register A
    {cntWr, cntData, genAWr, genAData} <= {1'b1, 16'h0002, 1'b1, 16'h0005};
    idle();
    @(posedge core_clk) ioModeWr <= 1'b1;
    idle();
    chk("cnt", 16'h0002, channelCounter);
    chk("regA", 16'h0005, generalRegA);
    chk("initLow", 16'h0000, pinLevel);
    // Other unit held high, so any leak onto the vector is counted
    @(posedge core_clk) {channelStart, otherUnitIrq} <= 2'h3;
    repeat (30) @(posedge core_clk);
    irqs = 0;
    repeat (24) begin
      @(posedge core_clk);
      #1 irqs += int'(sharedVectorIrq === 1'b1);
    end
    #1 chk("halfLen", 16'h0006, halfLen);
    chk("irqs", 16'h0004, 16'(irqs));
    @(posedge core_clk) channelStart <= 1'b0;
    vectorSelect <= 1'b1;
    idle();
    held = channelCounter;
    repeat (3) @(posedge core_clk);
    #1 chk("halted", held, channelCounter);
    chk("other", 16'h0001, sharedVectorIrq);
    @(posedge core_clk) cfg.operatingModeField <= 4'h1;
    channelStart <= 1'b1;
    idle();
    held = channelCounter;
    repeat (3) @(posedge core_clk);
    #1 chk("modeHalt", held, channelCounter);
    // Divide by four and a fresh low start; the load write eats one tick
    @(posedge core_clk) cfg <= '{`TCC_PSC_DIV4, 2'h0, `TCC_CLR_MATCH_A,
      `TCC_IO_TOGGLE_LO, `TCC_MODE_NORMAL, 1'b0, 1'b0};
    {cntWr, cntData, ioModeWr} <= {1'b1, 16'h0000, 1'b1};
    idle();
    chk("reinit", 16'h0000, pinLevel);
    repeat (8) @(posedge core_clk);
    #1 chk("div4", 16'h0002, channelCounter);
  endtask
  // Watchdog cuts a hang short
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {rst, protWr, modStopWr, modStopData, channelStart} = 5'h10;
    {ioModeWr, cntWr, genAWr, outMasterEnable, portModePeriph} = 5'h00;
    {vectorSelect, otherUnitIrq, protData, cntData, genAData} = '0;
    cfg = '0;
    pinCfg = '0;
    mismatches = 0;
    nChecks = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_stopped();
    t_release();
    t_route();
    t_pulse();
    give_verdict();
  end
endmodule
`default_nettype wire
